// file: dv/btc_chk.sv
`timescale 1ns/1ps
module btc_chk (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_s_awvalid,
	input wire logic o_s_awready,
	input wire logic i_s_wvalid,
	input wire logic o_s_wready,
	input wire logic [1:0] o_s_bresp,
	input wire logic o_s_bvalid,
	input wire logic i_s_bready,
	input wire logic i_s_arvalid,
	input wire logic o_s_arready,
	input wire logic [31:0] o_s_rdata,
	input wire logic [1:0] o_s_rresp,
	input wire logic o_s_rvalid,
	input wire logic i_s_rready,
	input wire btc_pkg::btc_phase_s i_phase,
	input wire btc_pkg::btc_synth_s o_synth,
	input wire logic o_sync
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// Bus answers hold until taken, no second request meanwhile
	property p_bhold; o_s_bvalid && !i_s_bready |=> o_s_bvalid && $stable(o_s_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	property p_rhold; o_s_rvalid && !i_s_rready |=> o_s_rvalid && $stable(o_s_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped early");
	property p_wblock; o_s_bvalid |-> !o_s_awready && !o_s_wready; endproperty
	a_wblock: assert property (p_wblock) else $error("write accepted while response pending");
	property p_rblock; o_s_rvalid |-> !o_s_arready; endproperty
	a_rblock: assert property (p_rblock) else $error("read accepted while data pending");
	property p_wlat; i_s_awvalid && o_s_awready && i_s_wvalid && o_s_wready |-> ##2 o_s_bvalid; endproperty
	a_wlat: assert property (p_wlat) else $error("write response late");
	property p_rlat; i_s_arvalid && o_s_arready |=> o_s_rvalid; endproperty
	a_rlat: assert property (p_rlat) else $error("read data late");
	// Forced level only while stopped
	property p_idle; o_synth.idle_force |-> !o_synth.run; endproperty
	a_idle: assert property (p_idle) else $error("idle level forced while running");
	// Stop lands one clock after a whole or half cycle boundary
	property p_stop; $fell(o_synth.run) |-> $past(i_phase.start_mark) || $past(i_phase.half_mark); endproperty
	a_stop: assert property (p_stop) else $error("stop off phase");
	property p_sync; (o_sync == !o_synth.run) || (o_sync == $past(i_phase.ref_half)); endproperty
	a_sync: assert property (p_sync) else $error("sync output unrelated");
	c_burst: cover property (o_synth.run ##1 !o_synth.run);
	c_idle: cover property (o_synth.idle_force);
	c_err: cover property (o_s_rvalid && o_s_rresp == btc_pkg::RESP_SLVERR);
endmodule
bind btc_burst_ctrl btc_chk btc_chk_inst (.i_clk, .i_sys_rst, .i_s_awvalid, .o_s_awready, .i_s_wvalid, .o_s_wready,
	.o_s_bresp, .o_s_bvalid, .i_s_bready, .i_s_arvalid, .o_s_arready, .o_s_rdata, .o_s_rresp, .o_s_rvalid,
	.i_s_rready, .i_phase, .o_synth, .o_sync);

// file: dv/btc_phase_model.sv
`timescale 1ns/1ps
// Synthesis path stand-in: an 8-clock waveform whose phase events keep ticking while muted
module btc_phase_model (
	input wire logic i_clk,
	output btc_pkg::btc_phase_s o_phase
);
	logic [2:0] pos_ff = 3'h0;
	// Free phase accumulator, start/stop phase at 0, opposite phase at 4
	always @(posedge i_clk) begin
		pos_ff <= pos_ff + 3'h1;
		o_phase.ref_half <= (pos_ff < 3'h4);
		o_phase.start_mark <= (pos_ff == 3'h0);
		o_phase.half_mark <= (pos_ff == 3'h4);
	end
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
	logic i_clk = 1'h0;
	logic i_sys_rst = 1'h1;
	logic [7:0] i_s_awaddr = 8'h00;
	logic [7:0] i_s_araddr = 8'h00;
	logic [31:0] i_s_wdata = 32'h0;
	logic i_s_awvalid = 1'h0, i_s_wvalid = 1'h0, i_s_bready = 1'h0, i_s_arvalid = 1'h0, i_s_rready = 1'h0;
	logic i_ext_trig = 1'h0, i_manual_trigger_key = 1'h0;
	logic o_s_awready, o_s_wready, o_s_bvalid, o_s_arready, o_s_rvalid, o_sync, o_trig_seen, ref_d, aw, w;
	logic [1:0] o_s_bresp, o_s_rresp, resp;
	logic [31:0] o_s_rdata, rd;
	btc_pkg::btc_phase_s i_phase;
	btc_pkg::btc_synth_s o_synth;
	int n_mismatch = 0, cmp_count = 0, bcnt = 0, n, n2, mark, dly;
	logic [7:0] offs [7] = '{btc_pkg::OFF_CTRL, btc_pkg::OFF_MARK, btc_pkg::OFF_SPACE, btc_pkg::OFF_DELAY,
		btc_pkg::OFF_PERIOD, btc_pkg::OFF_LEVEL, btc_pkg::OFF_WAVE};
	logic [31:0] rstv [7] = '{btc_pkg::CTRL_RST, 32'(btc_pkg::MARK_RST), 32'(btc_pkg::SPACE_RST), btc_pkg::DELAY_RST,
		btc_pkg::PERIOD_RST, 32'(btc_pkg::LEVEL_RST), 32'(btc_pkg::WAVE_RST)};
	always #50 i_clk = ~i_clk;
	btc_phase_model btc_phase_model_inst (.i_clk, .o_phase(i_phase));
	btc_burst_ctrl btc_burst_ctrl_inst (.i_clk, .i_sys_rst, .i_s_awaddr, .i_s_awvalid, .o_s_awready, .i_s_wdata,
		.i_s_wstrb(4'hF), .i_s_wvalid, .o_s_wready, .o_s_bresp, .o_s_bvalid, .i_s_bready, .i_s_araddr,
		.i_s_arvalid, .o_s_arready, .o_s_rdata, .o_s_rresp, .o_s_rvalid, .i_s_rready, .i_phase,
		.i_ext_trig, .i_manual_trigger_key, .o_synth, .o_sync, .o_trig_seen);
	// Boundaries passed while running; cleared whenever stopped
	always @(posedge i_clk) begin
		ref_d <= i_phase.ref_half;
		if (!o_synth.run)
			bcnt <= 0;
		else if (i_phase.start_mark || i_phase.half_mark)
			bcnt <= bcnt + 1;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic finish_test;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic rst;
		i_sys_rst <= 1'h1;
		repeat (12) @(posedge i_clk);
		i_sys_rst <= 1'h0;
		@(posedge i_clk);
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		aw = 0;
		w = 0;
		i_s_awaddr <= a;
		i_s_wdata <= d;
		i_s_awvalid <= 1'h1;
		i_s_wvalid <= 1'h1;
		i_s_bready <= 1'h1;
		while (!(aw && w)) begin
			@(posedge i_clk);
			if (i_s_awvalid && o_s_awready) begin
				aw = 1;
				i_s_awvalid <= 1'h0;
			end
			if (i_s_wvalid && o_s_wready) begin
				w = 1;
				i_s_wvalid <= 1'h0;
			end
		end
		do @(posedge i_clk); while (o_s_bvalid !== 1'h1);
		resp = o_s_bresp;
		i_s_bready <= 1'h0;
		@(posedge i_clk);
	endtask
	task automatic rdr(input logic [7:0] a);
		i_s_araddr <= a;
		i_s_arvalid <= 1'h1;
		i_s_rready <= 1'h1;
		do @(posedge i_clk); while (!(i_s_arvalid && o_s_arready));
		i_s_arvalid <= 1'h0;
		do @(posedge i_clk); while (o_s_rvalid !== 1'h1);
		rd = o_s_rdata;
		resp = o_s_rresp;
		i_s_rready <= 1'h0;
		@(posedge i_clk);
	endtask
	// Edges until the run flag shows the wanted level
	task automatic wait_run(input logic v, output int c);
		c = 0;
		do begin
			@(posedge i_clk);
			c++;
		end while (o_synth.run !== v && c < 3000);
	endtask
	task automatic quiet(input int c);
		repeat (c) begin
			@(posedge i_clk);
			chk(o_synth.run, 1'h0);
			chk(o_trig_seen, 1'h0);
		end
	endtask
	initial begin
		#(100 * 30000);
		n_mismatch++;
		finish_test();
	end
	initial begin
		void'($urandom(32'hFC7E));
		rst();
		for (int i = 0; i < 7; i++) begin
			rdr(offs[i]);
			chk(rd, rstv[i]);
			chk(resp, btc_pkg::RESP_OKAY);
		end
		rdr(8'h40);
		chk(rd, 32'h0);
		chk(resp, btc_pkg::RESP_SLVERR);
		wr(8'h40, 32'h5);
		chk(resp, btc_pkg::RESP_SLVERR);
		// Auto kind: a conflict withholds, a fix starts at once, then mark and space alternate
		mark = $urandom_range(1, 6);
		wr(btc_pkg::OFF_MARK, 32'h0);
		wr(btc_pkg::OFF_CTRL, 32'h09);
		quiet(40);
		wr(btc_pkg::OFF_MARK, mark);
		wait_run(1'h1, n);
		chk(n < 20, 1'h1);
		chk(o_sync, 1'h0);
		wait_run(1'h0, n);
		chk(bcnt, mark);
		chk(o_sync, 1'h1);
		wait_run(1'h1, n);
		chk(n < 17, 1'h1);
		wr(btc_pkg::OFF_CTRL, 32'h2B);
		wait_run(1'h0, n);
		quiet(40);
		// Trigger kind from the key: no delay, retrigger ignored, odd half-cycle count
		wr(btc_pkg::OFF_MARK, 32'h3);
		wr(btc_pkg::OFF_DELAY, 32'h32);
		i_manual_trigger_key <= 1'h1;
		wait_run(1'h1, n);
		chk(n, 3);
		chk(o_trig_seen, 1'h1);
		i_manual_trigger_key <= 1'h0;
		@(posedge i_clk);
		i_manual_trigger_key <= 1'h1;
		@(posedge i_clk);
		i_manual_trigger_key <= 1'h0;
		wait_run(1'h0, n);
		chk(bcnt, 3);
		quiet(20);
		wr(btc_pkg::OFF_REMOTE, 32'h1);
		wait_run(1'h1, n);
		chk(n < 10, 1'h1);
		wait_run(1'h0, n);
		// External pin, both polarities, zero and random delay
		for (int k = 0; k < 2; k++) begin
			dly = k ? $urandom_range(1, 60) : 0;
			// Polarity off while the pin moves to its new idle level, else a stray edge fires
			wr(btc_pkg::OFF_CTRL, 32'h2B);
			i_ext_trig <= k;
			wr(btc_pkg::OFF_DELAY, dly);
			wr(btc_pkg::OFF_CTRL, 32'h6B | (k << 7));
			i_ext_trig <= !k;
			wait_run(1'h1, n);
			chk(n, 3 + dly);
			i_ext_trig <= k;
			wait_run(1'h0, n);
		end
		wr(btc_pkg::OFF_CTRL, 32'h2B);
		i_ext_trig <= 1'h0;
		quiet(20);
		// Internal source: one start per period
		wr(btc_pkg::OFF_DELAY, 32'h0);
		wr(btc_pkg::OFF_PERIOD, 32'hC8);
		wr(btc_pkg::OFF_CTRL, 32'h0B);
		wait_run(1'h1, n);
		wait_run(1'h0, n);
		wait_run(1'h1, n);
		wait_run(1'h0, n);
		wait_run(1'h1, n2);
		chk(n + n2, 200);
		rst();
		for (int k = 6; k < 8; k++) begin
			wr(btc_pkg::OFF_WAVE, k);
			wr(btc_pkg::OFF_CTRL, 32'h2B);
			i_manual_trigger_key <= 1'h1;
			quiet(20);
			i_manual_trigger_key <= 1'h0;
		end
		// Square with override: three levels
		dly = $urandom_range(0, 255);
		wr(btc_pkg::OFF_WAVE, btc_pkg::WAVE_SQUARE);
		wr(btc_pkg::OFF_LEVEL, dly);
		wr(btc_pkg::OFF_CTRL, 32'h3B);
		@(posedge i_clk);
		chk({o_synth.idle_force, o_synth.idle_level}, {1'h1, dly[7:0]});
		i_manual_trigger_key <= 1'h1;
		wait_run(1'h1, n);
		chk(o_synth.idle_force, 1'h0);
		i_manual_trigger_key <= 1'h0;
		wait_run(1'h0, n);
		@(posedge i_clk);
		chk(o_synth.idle_force, 1'h1);
		wr(btc_pkg::OFF_CTRL, 32'h23);
		repeat (16) begin
			@(posedge i_clk);
			chk(o_sync, ref_d);
		end
		// Gate kind from the held key: runs while held, then drains to the start phase
		wr(btc_pkg::OFF_CTRL, 32'h2D);
		i_manual_trigger_key <= 1'h1;
		wait_run(1'h1, n);
		chk(n, 3);
		chk(o_trig_seen, 1'h1);
		repeat (20) begin
			@(posedge i_clk);
			chk(o_synth.run, 1'h1);
		end
		i_manual_trigger_key <= 1'h0;
		wait_run(1'h0, n);
		chk(n > 3 && n < 12, 1'h1);
		finish_test();
	end
endmodule

// file: verilog/btc_burst_ctrl.sv
`timescale 1ns/1ps
module btc_burst_ctrl (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [7:0] i_s_awaddr,
	input wire logic i_s_awvalid,
	output logic o_s_awready,
	input wire logic [31:0] i_s_wdata,
	input wire logic [3:0] i_s_wstrb,
	input wire logic i_s_wvalid,
	output logic o_s_wready,
	output logic [1:0] o_s_bresp,
	output logic o_s_bvalid,
	input wire logic i_s_bready,
	input wire logic [7:0] i_s_araddr,
	input wire logic i_s_arvalid,
	output logic o_s_arready,
	output logic [31:0] o_s_rdata,
	output logic [1:0] o_s_rresp,
	output logic o_s_rvalid,
	input wire logic i_s_rready,
	input wire btc_pkg::btc_phase_s i_phase,
	input wire logic i_ext_trig,
	input wire logic i_manual_trigger_key,
	output btc_pkg::btc_synth_s o_synth,
	output logic o_sync,
	output logic o_trig_seen
);
	typedef struct packed {
		logic [31:0] ctrl;
		logic [15:0] mark;
		logic [15:0] space;
		logic [31:0] delay;
		logic [31:0] period;
		logic [7:0] level;
		logic [2:0] wave;
		btc_pkg::btc_state_e st;
		logic tgate;
		logic remote;
		logic aw_held;
		logic w_held;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		btc_pkg::btc_synth_s synth;
		logic sync;
		logic trig_seen;
	} btc_top_s;
	btc_top_s s_ff;
	btc_top_s nxt_s;
	logic src_pulse;
	logic direct_pulse;
	logic gate_level;
	logic [15:0] cnt;
	logic [31:0] dly;
	logic cnt_load;
	logic [15:0] cnt_val;
	logic cnt_dec;
	logic dly_load;
	logic dly_dec;
	logic [31:0] wr_val;
	logic bnd;
	logic en;
	logic conflict;
	logic gate_on;
	logic any_trig;
	btc_pkg::btc_kind_e kind;
	// Address decode shared by read and write paths
	function automatic logic mapped(input logic [7:0] a);
		case (a)
			btc_pkg::OFF_CTRL, btc_pkg::OFF_MARK, btc_pkg::OFF_SPACE,
			btc_pkg::OFF_DELAY, btc_pkg::OFF_PERIOD, btc_pkg::OFF_LEVEL,
			btc_pkg::OFF_WAVE, btc_pkg::OFF_REMOTE, btc_pkg::OFF_STATUS: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	endfunction
	// Current register value; also the base for byte-lane merges
	function automatic logic [31:0] rd_value(input btc_top_s s, input logic [7:0] a);
		case (a)
			btc_pkg::OFF_CTRL: rd_value = s.ctrl;
			btc_pkg::OFF_MARK: rd_value = {16'h0000, s.mark};
			btc_pkg::OFF_SPACE: rd_value = {16'h0000, s.space};
			btc_pkg::OFF_DELAY: rd_value = s.delay;
			btc_pkg::OFF_PERIOD: rd_value = s.period;
			btc_pkg::OFF_LEVEL: rd_value = {24'h000000, s.level};
			btc_pkg::OFF_WAVE: rd_value = {29'h00000000, s.wave};
			btc_pkg::OFF_STATUS: rd_value = {24'h000000, s.st, s.tgate, s.trig_seen,
				s.synth.run, s.sync, 1'b0};
			default: rd_value = 32'h0000_0000;
		endcase
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = strb[i] ? d[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction
	btc_trig_src #(
		.PW(32)
	) u_src (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_period(s_ff.period),
		.i_src_ext(s_ff.ctrl[btc_pkg::CTRL_SRC_BIT]),
		.i_pol_en(s_ff.ctrl[btc_pkg::CTRL_POL_EN_BIT]),
		.i_pol_neg(s_ff.ctrl[btc_pkg::CTRL_POL_NEG_BIT]),
		.i_ext_trig(i_ext_trig),
		.i_manual_trigger_key(i_manual_trigger_key),
		.i_remote(s_ff.remote),
		.o_src_pulse(src_pulse),
		.o_direct_pulse(direct_pulse),
		.o_gate_level(gate_level)
	);
	// Half-cycle counter for mark and space
	btc_down_counter #(
		.W(16)
	) u_half_cnt (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_load(cnt_load),
		.i_value(cnt_val),
		.i_dec(cnt_dec),
		.o_count(cnt)
	);
	// Start delay counter in clock cycles
	btc_down_counter #(
		.W(32)
	) u_delay_cnt (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_load(dly_load),
		.i_value(s_ff.delay),
		.i_dec(dly_dec),
		.o_count(dly)
	);
	// Register slave, burst sequencer and output staging
	always_comb begin
		nxt_s = s_ff;
		cnt_load = 1'b0;
		cnt_val = s_ff.mark;
		cnt_dec = 1'b0;
		dly_load = 1'b0;
		dly_dec = 1'b0;
		nxt_s.remote = 1'b0;
		wr_val = merge(rd_value(s_ff, s_ff.awaddr), s_ff.wdata, s_ff.wstrb);
		kind = btc_pkg::btc_kind_e'(s_ff.ctrl[btc_pkg::CTRL_KIND_LSB +: 2]);
		en = s_ff.ctrl[btc_pkg::CTRL_EN_BIT];
		bnd = i_phase.start_mark || i_phase.half_mark;
		any_trig = src_pulse || direct_pulse;
		// Write channel: address and data in either order
		if (s_ff.awready && i_s_awvalid) begin
			nxt_s.aw_held = 1'b1;
			nxt_s.awaddr = i_s_awaddr;
		end
		if (s_ff.wready && i_s_wvalid) begin
			nxt_s.w_held = 1'b1;
			nxt_s.wdata = i_s_wdata;
			nxt_s.wstrb = i_s_wstrb;
		end
		if (s_ff.bvalid && i_s_bready) begin
			nxt_s.bvalid = 1'b0;
		end
		if (s_ff.aw_held && s_ff.w_held && !s_ff.bvalid) begin
			nxt_s.aw_held = 1'b0;
			nxt_s.w_held = 1'b0;
			nxt_s.bvalid = 1'b1;
			nxt_s.bresp = mapped(s_ff.awaddr) ? btc_pkg::RESP_OKAY : btc_pkg::RESP_SLVERR;
			case (s_ff.awaddr)
				btc_pkg::OFF_CTRL: nxt_s.ctrl = wr_val;
				btc_pkg::OFF_MARK: nxt_s.mark = wr_val[15:0];
				btc_pkg::OFF_SPACE: nxt_s.space = wr_val[15:0];
				btc_pkg::OFF_DELAY: nxt_s.delay = wr_val;
				btc_pkg::OFF_PERIOD: nxt_s.period = wr_val;
				btc_pkg::OFF_LEVEL: nxt_s.level = wr_val[7:0];
				btc_pkg::OFF_WAVE: nxt_s.wave = wr_val[2:0];
				btc_pkg::OFF_REMOTE: nxt_s.remote = s_ff.wstrb[0] && s_ff.wdata[0];
				default: ;
			endcase
		end
		// One outstanding write: no new address until the answer is taken
		nxt_s.awready = !nxt_s.aw_held && !nxt_s.bvalid;
		nxt_s.wready = !nxt_s.w_held && !nxt_s.bvalid;
		// Read channel
		if (s_ff.rvalid && i_s_rready) begin
			nxt_s.rvalid = 1'b0;
		end
		if (s_ff.arready && i_s_arvalid) begin
			nxt_s.rvalid = 1'b1;
			nxt_s.rdata = rd_value(s_ff, i_s_araddr);
			nxt_s.rresp = mapped(i_s_araddr) ? btc_pkg::RESP_OKAY : btc_pkg::RESP_SLVERR;
		end
		nxt_s.arready = !nxt_s.rvalid;
		// Settings that forbid the selected kind
		conflict = 1'b0;
		if (kind == btc_pkg::BK_AUTO || kind == btc_pkg::BK_TRIG) begin
			conflict = (s_ff.mark == 16'h0000) || (s_ff.wave == btc_pkg::WAVE_NOISE)
				|| (s_ff.wave == btc_pkg::WAVE_DC);
		end else begin
			conflict = (s_ff.wave == btc_pkg::WAVE_DC);
		end
		// Triggered gate flips its gate on every trigger
		if (kind == btc_pkg::BK_TGATE && any_trig) begin
			nxt_s.tgate = !s_ff.tgate;
		end
		gate_on = (kind == btc_pkg::BK_GATE) ? gate_level : nxt_s.tgate;
		// Burst sequencer; the synthesis path keeps its phase running while idle
		if (!en || conflict) begin
			nxt_s.st = btc_pkg::ST_IDLE;
			nxt_s.tgate = 1'b0;
		end else begin
			case (s_ff.st)
				btc_pkg::ST_IDLE: begin
					case (kind)
						btc_pkg::BK_AUTO: begin
							nxt_s.st = btc_pkg::ST_MARK;
							cnt_load = 1'b1;
						end
						btc_pkg::BK_TRIG: begin
							if (direct_pulse) begin
								nxt_s.st = btc_pkg::ST_MARK;
								cnt_load = 1'b1;
							end else if (src_pulse && s_ff.delay == 32'h0000_0000) begin
								nxt_s.st = btc_pkg::ST_MARK;
								cnt_load = 1'b1;
							end else if (src_pulse) begin
								nxt_s.st = btc_pkg::ST_DELAY;
								dly_load = 1'b1;
							end
						end
						default: begin
							if (gate_on) begin
								nxt_s.st = btc_pkg::ST_GATE;
							end
						end
					endcase
				end
				btc_pkg::ST_DELAY: begin
					// Further triggers are dropped here and in mark
					dly_dec = 1'b1;
					if (dly <= 32'h0000_0001) begin
						nxt_s.st = btc_pkg::ST_MARK;
						cnt_load = 1'b1;
					end
				end
				btc_pkg::ST_MARK: begin
					if (bnd) begin
						if (cnt <= 16'h0001) begin
							// Leaving auto only at the end of a run
							if (kind == btc_pkg::BK_AUTO && s_ff.space != 16'h0000) begin
								nxt_s.st = btc_pkg::ST_SPACE;
								cnt_load = 1'b1;
								cnt_val = s_ff.space;
							end else if (kind == btc_pkg::BK_AUTO) begin
								cnt_load = 1'b1;
							end else begin
								nxt_s.st = btc_pkg::ST_IDLE;
							end
						end else begin
							cnt_dec = 1'b1;
						end
					end
				end
				btc_pkg::ST_SPACE: begin
					if (bnd) begin
						if (cnt <= 16'h0001) begin
							nxt_s.st = (kind == btc_pkg::BK_AUTO) ? btc_pkg::ST_MARK : btc_pkg::ST_IDLE;
							cnt_load = 1'b1;
						end else begin
							cnt_dec = 1'b1;
						end
					end
				end
				btc_pkg::ST_GATE: begin
					if (kind != btc_pkg::BK_GATE && kind != btc_pkg::BK_TGATE) begin
						nxt_s.st = btc_pkg::ST_DRAIN;
					end else if (!gate_on) begin
						nxt_s.st = btc_pkg::ST_DRAIN;
					end
				end
				btc_pkg::ST_DRAIN: begin
					// Half unit may also stop at start phase plus 180 degrees
					if (gate_on && (kind == btc_pkg::BK_GATE || kind == btc_pkg::BK_TGATE)) begin
						nxt_s.st = btc_pkg::ST_GATE;
					end else if (i_phase.start_mark
						|| (s_ff.ctrl[btc_pkg::CTRL_HALF_BIT] && i_phase.half_mark)) begin
						nxt_s.st = btc_pkg::ST_IDLE;
					end
				end
				default: begin
					nxt_s.st = btc_pkg::ST_IDLE;
				end
			endcase
		end
		// Outputs staged from the next state so they leave a flip-flop
		nxt_s.synth.run = (nxt_s.st == btc_pkg::ST_MARK) || (nxt_s.st == btc_pkg::ST_GATE)
			|| (nxt_s.st == btc_pkg::ST_DRAIN);
		// Override applies to any wave; on a square it makes a third level
		nxt_s.synth.idle_force = nxt_s.ctrl[btc_pkg::CTRL_IDLE_BIT] && !nxt_s.synth.run;
		nxt_s.synth.idle_level = nxt_s.level;
		nxt_s.sync = nxt_s.ctrl[btc_pkg::CTRL_SYNC_BIT] ? !nxt_s.synth.run
			: i_phase.ref_half;
		nxt_s.trig_seen = (nxt_s.st == btc_pkg::ST_DELAY)
			|| (nxt_s.st == btc_pkg::ST_MARK && kind == btc_pkg::BK_TRIG)
			|| (nxt_s.st == btc_pkg::ST_GATE);
	end
	// One register bank for every piece of state
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_ff <= '0;
			s_ff.ctrl <= btc_pkg::CTRL_RST;
			s_ff.mark <= btc_pkg::MARK_RST;
			s_ff.space <= btc_pkg::SPACE_RST;
			s_ff.delay <= btc_pkg::DELAY_RST;
			s_ff.period <= btc_pkg::PERIOD_RST;
			s_ff.level <= btc_pkg::LEVEL_RST;
			s_ff.wave <= btc_pkg::WAVE_RST;
			s_ff.st <= btc_pkg::ST_IDLE;
			s_ff.sync <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end
	assign o_s_awready = s_ff.awready;
	assign o_s_wready = s_ff.wready;
	assign o_s_bvalid = s_ff.bvalid;
	assign o_s_bresp = s_ff.bresp;
	assign o_s_arready = s_ff.arready;
	assign o_s_rvalid = s_ff.rvalid;
	assign o_s_rdata = s_ff.rdata;
	assign o_s_rresp = s_ff.rresp;
	assign o_synth = s_ff.synth;
	assign o_sync = s_ff.sync;
	assign o_trig_seen = s_ff.trig_seen;
endmodule

// file: verilog/btc_down_counter.sv
`timescale 1ns/1ps
module btc_down_counter #(
	parameter int W = 16
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_load,
	input wire logic [W-1:0] i_value,
	input wire logic i_dec,
	output logic [W-1:0] o_count
);
	typedef struct packed {
		logic [W-1:0] count;
	} btc_cnt_s;

	btc_cnt_s s_ff;
	btc_cnt_s nxt_s;

	// Load wins over decrement; stops at zero
	always_comb begin
		nxt_s = s_ff;
		if (i_load) begin
			nxt_s.count = i_value;
		end else if (i_dec && s_ff.count != '0) begin
			nxt_s.count = s_ff.count - W'(1);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_count = s_ff.count;
endmodule

// file: verilog/btc_pkg.sv
package btc_pkg;
	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_MARK = 8'h04;
	localparam logic [7:0] OFF_SPACE = 8'h08;
	localparam logic [7:0] OFF_DELAY = 8'h0C;
	localparam logic [7:0] OFF_PERIOD = 8'h10;
	localparam logic [7:0] OFF_LEVEL = 8'h14;
	localparam logic [7:0] OFF_WAVE = 8'h18;
	localparam logic [7:0] OFF_REMOTE = 8'h1C;
	localparam logic [7:0] OFF_STATUS = 8'h20;

	// Control word field positions
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_KIND_LSB = 1;
	localparam int CTRL_SYNC_BIT = 3;
	localparam int CTRL_IDLE_BIT = 4;
	localparam int CTRL_SRC_BIT = 5;
	localparam int CTRL_POL_EN_BIT = 6;
	localparam int CTRL_POL_NEG_BIT = 7;
	localparam int CTRL_HALF_BIT = 8;

	// Values after reset
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] MARK_RST = 16'h0002;
	localparam logic [15:0] SPACE_RST = 16'h0002;
	localparam logic [31:0] DELAY_RST = 32'h0000_0000;
	localparam logic [31:0] PERIOD_RST = 32'h0000_2710;
	localparam logic [7:0] LEVEL_RST = 8'h00;
	localparam logic [2:0] WAVE_RST = 3'h0;

	// Waveform kinds held in the wave register; noise and DC are checked for conflicts
	localparam logic [2:0] WAVE_SQUARE = 3'h1;
	localparam logic [2:0] WAVE_NOISE = 3'h6;
	localparam logic [2:0] WAVE_DC = 3'h7;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {BK_AUTO, BK_TRIG, BK_GATE, BK_TGATE} btc_kind_e;
	typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_MARK, ST_SPACE, ST_GATE, ST_DRAIN} btc_state_e;

	// Phase events from the synthesis path
	typedef struct packed {
		logic ref_half;
		logic start_mark;
		logic half_mark;
	} btc_phase_s;

	// Commands toward the synthesis path
	typedef struct packed {
		logic run;
		logic idle_force;
		logic [7:0] idle_level;
	} btc_synth_s;
endpackage

// file: verilog/btc_trig_src.sv
`timescale 1ns/1ps
module btc_trig_src #(
	parameter int PW = 32
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic [PW-1:0] i_period,
	input wire logic i_src_ext,
	input wire logic i_pol_en,
	input wire logic i_pol_neg,
	input wire logic i_ext_trig,
	input wire logic i_manual_trigger_key,
	input wire logic i_remote,
	output logic o_src_pulse,
	output logic o_direct_pulse,
	output logic o_gate_level
);
	typedef struct packed {
		logic [PW-1:0] per_cnt;
		logic ext_prev;
		logic key_prev;
		logic src_pulse;
		logic direct_pulse;
		logic gate_level;
	} btc_src_s;

	btc_src_s s_ff;
	btc_src_s nxt_s;
	logic ext_act;
	logic int_pulse;

	// Free-running period counter, one pulse per period
	always_comb begin
		nxt_s = s_ff;
		ext_act = i_pol_en && (i_ext_trig ^ i_pol_neg);
		int_pulse = 1'b0;
		if (i_period == '0) begin
			nxt_s.per_cnt = '0;
		end else if (s_ff.per_cnt >= i_period - PW'(1)) begin
			nxt_s.per_cnt = '0;
			int_pulse = 1'b1;
		end else begin
			nxt_s.per_cnt = s_ff.per_cnt + PW'(1);
		end
		nxt_s.ext_prev = ext_act;
		nxt_s.key_prev = i_manual_trigger_key;
		// Polarity off silences the external pin entirely
		nxt_s.src_pulse = i_src_ext ? (ext_act && !s_ff.ext_prev) : int_pulse;
		nxt_s.direct_pulse = (i_manual_trigger_key && !s_ff.key_prev) || i_remote;
		// Internal gate is a 50% square over the period
		nxt_s.gate_level = (i_src_ext ? ext_act : (s_ff.per_cnt < (i_period >> 1)))
			|| i_manual_trigger_key || i_remote;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign o_src_pulse = s_ff.src_pulse;
	assign o_direct_pulse = s_ff.direct_pulse;
	assign o_gate_level = s_ff.gate_level;
endmodule
